// ---- core/spi_frame_link.sv ----
// serial frame shifter running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_frame_link
	import status_pkg::*;
#(
	parameter int BITS = FRAME_BITS
) (
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic rst_n_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	spi_link_if.link link
);
	logic [4:0] cnt_reg;
	logic [BITS-1:0] shift_reg;
	logic [BITS-1:0] word_reg;
	logic toggle_reg;

	// the serial clock stands still outside frames, so select ends the count
	always_ff @(posedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			cnt_reg <= 5'h00;
			shift_reg <= '0;
		end else begin
			if (cnt_reg != 5'(BITS))
				cnt_reg <= cnt_reg + 5'h01;
			shift_reg <= {shift_reg[BITS-2:0], sdi_in};
		end
	end

	// word and toggle survive deselect; only the chip reset clears them
	always_ff @(posedge sck_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_reg <= '0;
			toggle_reg <= 1'h0;
		end else if (!cs_n_in && cnt_reg == 5'(BITS - 1)) begin
			word_reg <= {shift_reg[BITS-2:0], sdi_in};
			toggle_reg <= ~toggle_reg;
		end
	end

	assign link.rx_word = word_reg;
	assign link.rx_toggle = toggle_reg;
	// tx word is frozen by the core for the whole frame
	assign sdo_out = (cnt_reg < 5'(BITS)) ?
		link.tx_word[4'(BITS - 1) - cnt_reg[3:0]] : 1'h0;
	assign sdo_oe_out = ~cs_n_in;
endmodule // spi_frame_link
`default_nettype wire

// ---- core/system_status_readback.sv ----
// system status word with clear-on-read flags and mode write-through
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - address 00 in a read frame returns the system status word.
// - no-write bit 1 returns status and leaves mode register alone.
// - no-write bit 0 returns status and writes frame bits to mode.
// - cause 0000 after power-on, battery drop, or external reset pin.
// - wake causes 0001, 0111, 1000, 1001, 1010 as listed.
// - supply causes 0010, 0011, 0100 as listed.
// - flash exit 0101, flash entry ready 0110.
// - watchdog causes 1011, 1100, 1101 as listed.
// - illegal serial access 1110, unserved interrupt 1111.
// - cause overwritten on each reset event, never cleared.
// - bit 7 sets on CAN wake, clears on status read.
// - bit 6 sets on LIN wake, clears on status read.
// - bit 5 latches wake pin falling edge, clears on status read.
// - bit 4 shows live wake pin level, not latched.
// - bit 3 shows live overtemperature warning.
// - bit 2 shows software development mode.
// - bit 1 shows enable pin driven high.
// - bit 0 set by power-on, cleared once Normal mode entered.
// - status word readable in every operating mode.
module system_status_readback
	import status_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic CE_IN,
	input wire logic SPI_SCK_IN,
	input wire logic SPI_CS_N_IN,
	input wire logic SPI_SDI_IN,
	output logic SPI_SDO_OUT,
	output logic SPI_SDO_OE_OUT,
	input wire logic CAN_WAKE_IN,
	input wire logic LIN_WAKE_IN,
	input wire logic WAKE_PIN_IN,
	input wire logic OVERTEMP_IN,
	input wire logic SW_DEV_MODE_IN,
	input wire logic ENABLE_PIN_STATE_IN,
	input wire logic NORMAL_ENTERED_IN,
	input wire logic [15:0] RESET_EVENTS_IN,
	output logic MODE_WRITE_OUT,
	output logic [11:0] MODE_DATA_OUT,
	output logic [15:0] STATUS_WORD_OUT
);
	spi_link_if link_bus ();

	logic [2:0] pin_meta_reg;
	logic [2:0] pin_sync_reg;
	logic wake_prev_reg;
	logic tog_meta_reg;
	logic tog_sync_reg;
	logic tog_seen_reg;
	logic can_wake_reg;
	logic lin_wake_reg;
	logic wake_edge_reg;
	logic poweron_reg;
	cause_t cause_reg;
	logic [15:0] tx_word_reg;
	logic [15:0] tx_word_next;
	logic mode_write_reg;
	logic [11:0] mode_data_reg;
	logic cs_n_s;
	logic wake_level_s;
	logic overtemp_s;
	logic frame_evt;
	logic status_read;
	logic freeze;
	logic wake_fall;
	logic [15:0] rx_word;

	// highest set event wins when several resets coincide
	function automatic cause_t cause_pick(input logic [15:0] ev);
		cause_t c;
		c = CAUSE_POR;
		for (int i = 0; i < 16; i++) begin
			if (ev[i])
				c = cause_t'(4'(i));
		end
		return c;
	endfunction

	spi_frame_link #(
		.BITS(FRAME_BITS)
	) u_link (
		.sck_in(SPI_SCK_IN),
		.cs_n_in(SPI_CS_N_IN),
		.rst_n_in(RESET_N_IN),
		.sdi_in(SPI_SDI_IN),
		.sdo_out(SPI_SDO_OUT),
		.sdo_oe_out(SPI_SDO_OE_OUT),
		.link(link_bus.link)
	);

	// select, wake pin and temperature comparator arrive from outside
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			pin_meta_reg <= 3'h1;
			pin_sync_reg <= 3'h1;
			wake_prev_reg <= 1'h0;
		end else if (CE_IN) begin
			pin_meta_reg <= {OVERTEMP_IN, WAKE_PIN_IN, SPI_CS_N_IN};
			pin_sync_reg <= pin_meta_reg;
			wake_prev_reg <= pin_sync_reg[1];
		end
	end

	assign cs_n_s = pin_sync_reg[0];
	assign wake_level_s = pin_sync_reg[1];
	assign overtemp_s = pin_sync_reg[2];
	assign wake_fall = wake_prev_reg && !wake_level_s;

	// frame completion crosses as a toggle
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			tog_meta_reg <= 1'h0;
			tog_sync_reg <= 1'h0;
			tog_seen_reg <= 1'h0;
		end else if (CE_IN) begin
			tog_meta_reg <= link_bus.rx_toggle;
			tog_sync_reg <= tog_meta_reg;
			tog_seen_reg <= tog_sync_reg;
		end
	end

	// word is stable for a whole frame after its toggle
	assign rx_word = link_bus.rx_word;
	assign frame_evt = CE_IN && (tog_sync_reg != tog_seen_reg);
	assign status_read = frame_evt && rx_word[READ_SEL_BIT] &&
		rx_word[ADDR_HI:ADDR_LO] == STATUS_ADDR;
	// no mode gating anywhere: every mode may read
	assign freeze = !cs_n_s || (tog_sync_reg != tog_seen_reg);

	// clear only what the host has seen; a new event in that cycle wins
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			can_wake_reg <= 1'h0;
		end else if (CE_IN) begin
			can_wake_reg <= CAN_WAKE_IN ||
				(can_wake_reg && !(status_read && tx_word_reg[CAN_WAKE_BIT]));
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			lin_wake_reg <= 1'h0;
		end else if (CE_IN) begin
			lin_wake_reg <= LIN_WAKE_IN ||
				(lin_wake_reg && !(status_read && tx_word_reg[LIN_WAKE_BIT]));
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			wake_edge_reg <= 1'h0;
		end else if (CE_IN) begin
			wake_edge_reg <= wake_fall ||
				(wake_edge_reg && !(status_read && tx_word_reg[WAKE_EDGE_BIT]));
		end
	end

	// chip reset is itself a power-on or reset-pin event
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			poweron_reg <= POWERON_RESET_VAL;
		end else if (CE_IN) begin
			if (RESET_EVENTS_IN[CAUSE_POR])
				poweron_reg <= 1'h1;
			else if (NORMAL_ENTERED_IN)
				poweron_reg <= 1'h0;
		end
	end

	// the cause is only ever overwritten, never cleared by a read
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			cause_reg <= CAUSE_RESET_VAL;
		end else if (CE_IN && RESET_EVENTS_IN != 16'h0000) begin
			cause_reg <= cause_pick(RESET_EVENTS_IN);
		end
	end
	// event index equals the code, covering the remaining cause groups

	always_comb begin
		tx_word_next = 16'h0000;
		tx_word_next[15:12] = TOP_NIBBLE_VAL;
		tx_word_next[CAUSE_HI:CAUSE_LO] = cause_reg;
		tx_word_next[CAN_WAKE_BIT] = can_wake_reg;
		tx_word_next[LIN_WAKE_BIT] = lin_wake_reg;
		tx_word_next[WAKE_EDGE_BIT] = wake_edge_reg;
		tx_word_next[WAKE_LEVEL_BIT] = wake_level_s;
		tx_word_next[OVERTEMP_BIT] = overtemp_s;
		tx_word_next[SW_DEV_BIT] = SW_DEV_MODE_IN;
		tx_word_next[ENABLE_BIT] = ENABLE_PIN_STATE_IN;
		tx_word_next[POWERON_BIT] = poweron_reg;
	end

	// the snapshot is frozen while a frame runs, so the link domain sees
	// a quiet word; a select edge faster than two cycles is a limitation
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			tx_word_reg <= 16'h0000;
		end else if (CE_IN && !freeze) begin
			tx_word_reg <= tx_word_next;
		end
	end

	assign link_bus.tx_word = tx_word_reg;
	assign STATUS_WORD_OUT = tx_word_reg;

	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			mode_write_reg <= 1'h0;
			mode_data_reg <= 12'h000;
		end else if (CE_IN) begin
			mode_write_reg <= status_read && !rx_word[NO_WRITE_BIT];
			if (status_read && !rx_word[NO_WRITE_BIT])
				mode_data_reg <= rx_word[MODE_BITS-1:0];
		end
	end

	assign MODE_WRITE_OUT = mode_write_reg;
	assign MODE_DATA_OUT = mode_data_reg;

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);

	sequence s_status_read;
		status_read;
	endsequence

	sequence s_keep_write;
		s_status_read ##0 rx_word[NO_WRITE_BIT];
	endsequence

	sequence s_do_write;
		s_status_read ##0 !rx_word[NO_WRITE_BIT];
	endsequence

	a_ro_no_write: assert property (s_keep_write |=> !MODE_WRITE_OUT)
		else $error("mode written on read-only access");
	a_mode_write: assert property (s_do_write |=> MODE_WRITE_OUT &&
		MODE_DATA_OUT == $past(rx_word[MODE_BITS-1:0]))
		else $error("mode not written on read-write access");
	a_can_set: assert property (CE_IN && CAN_WAKE_IN |=>
		can_wake_reg)
		else $error("can wake flag not set");
	a_can_clear: assert property (s_status_read ##0
		tx_word_reg[CAN_WAKE_BIT] && !CAN_WAKE_IN |=> !can_wake_reg)
		else $error("can wake flag not cleared by read");
	a_lin_clear: assert property (s_status_read ##0
		tx_word_reg[LIN_WAKE_BIT] && !LIN_WAKE_IN |=> !lin_wake_reg)
		else $error("lin wake flag not cleared by read");
	a_edge_latch: assert property (CE_IN && wake_fall |=>
		wake_edge_reg ##1 (wake_edge_reg || $past(status_read)))
		else $error("wake edge not latched");
	a_cause_hold: assert property (CE_IN && RESET_EVENTS_IN == 16'h0000
		|=> $stable(cause_reg))
		else $error("reset cause changed without event");
	a_cause_load: assert property (CE_IN && RESET_EVENTS_IN != 16'h0000
		|=> cause_reg == $past(cause_pick(RESET_EVENTS_IN)))
		else $error("reset cause not loaded");
	a_poweron_clear: assert property (CE_IN && NORMAL_ENTERED_IN &&
		!RESET_EVENTS_IN[CAUSE_POR] |=> !poweron_reg)
		else $error("power-on flag not cleared");
	a_live_temp: assert property (CE_IN && !freeze |=>
		tx_word_reg[OVERTEMP_BIT] == $past(overtemp_s))
		else $error("temperature bit not live");
	a_live_level: assert property (CE_IN && !freeze |=>
		tx_word_reg[WAKE_LEVEL_BIT] == $past(wake_level_s))
		else $error("wake level bit not live");

	sequence s_level_fall;
		CE_IN && wake_level_s ##1 CE_IN && !wake_level_s;
	endsequence

	sequence s_can_keep;
		CE_IN && can_wake_reg && !status_read;
	endsequence

	sequence s_lin_keep;
		CE_IN && lin_wake_reg && !status_read;
	endsequence

	sequence s_edge_keep;
		CE_IN && wake_edge_reg && !status_read;
	endsequence

	sequence s_por_event;
		CE_IN && RESET_EVENTS_IN[CAUSE_POR];
	endsequence

	a_lin_set: assert property (CE_IN && LIN_WAKE_IN |=>
		lin_wake_reg)
		else $error("lin wake flag not set");
	a_can_keep: assert property (s_can_keep |=> can_wake_reg)
		else $error("can wake flag lost without read");
	a_lin_keep: assert property (s_lin_keep |=> lin_wake_reg)
		else $error("lin wake flag lost without read");
	a_edge_keep: assert property (s_edge_keep |=> wake_edge_reg)
		else $error("wake edge flag lost without read");
	a_fall_seen: assert property (s_level_fall |=> wake_edge_reg)
		else $error("wake pin fall not latched");
	a_edge_clear: assert property (s_status_read ##0
		tx_word_reg[WAKE_EDGE_BIT] && !wake_fall |=> !wake_edge_reg)
		else $error("wake edge flag not cleared by read");
	a_poweron_set: assert property (s_por_event |=> poweron_reg)
		else $error("power-on flag not set");
	a_poweron_keep: assert property (CE_IN && poweron_reg &&
		!NORMAL_ENTERED_IN |=> poweron_reg)
		else $error("power-on flag cleared early");
	a_cause_por: assert property (CE_IN &&
		RESET_EVENTS_IN == 16'h0001 |=> cause_reg == CAUSE_POR)
		else $error("power-on cause not reported");
	a_cause_flash: assert property (CE_IN &&
		RESET_EVENTS_IN == 16'h0020 |=> cause_reg == CAUSE_FLASH_LEFT)
		else $error("flash exit cause not reported");
	a_cause_wdog: assert property (CE_IN &&
		RESET_EVENTS_IN == 16'h0800 |=> cause_reg == CAUSE_WDOG_OVERFLOW)
		else $error("watchdog cause not reported");
	a_cause_irq: assert property (CE_IN &&
		RESET_EVENTS_IN[CAUSE_IRQ_TIMEOUT] |=>
		cause_reg == CAUSE_IRQ_TIMEOUT)
		else $error("interrupt timeout cause not reported");
	a_live_swdev: assert property (CE_IN && !freeze |=>
		tx_word_reg[SW_DEV_BIT] == $past(SW_DEV_MODE_IN))
		else $error("software development bit not live");
	a_live_enable: assert property (CE_IN && !freeze |=>
		tx_word_reg[ENABLE_BIT] == $past(ENABLE_PIN_STATE_IN))
		else $error("enable pin bit not live");
	a_snap_frozen: assert property (freeze |=>
		$stable(tx_word_reg))
		else $error("status snapshot moved during a frame");
	a_frame_once: assert property (frame_evt |=> !frame_evt)
		else $error("one frame processed twice");
	a_mode_pulse: assert property (CE_IN && MODE_WRITE_OUT |=>
		!MODE_WRITE_OUT)
		else $error("mode write longer than one cycle");
	a_mode_hold: assert property (!(status_read &&
		!rx_word[NO_WRITE_BIT]) |=> $stable(MODE_DATA_OUT))
		else $error("mode data changed without a write");
endmodule // system_status_readback
`default_nettype wire

// ---- include/spi_link_if.sv ----
// carrier between the serial link logic and the status core
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic [15:0] rx_word;
	logic rx_toggle;
	logic [15:0] tx_word;
	modport link (output rx_word, output rx_toggle, input tx_word);
	modport core (input rx_word, input rx_toggle, output tx_word);
endinterface
`default_nettype wire

// ---- include/status_pkg.sv ----
// shared constants for the system status readback block
`default_nettype none
package status_pkg;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 14;
	localparam int READ_SEL_BIT = 13;
	localparam int NO_WRITE_BIT = 12;
	localparam int CAUSE_HI = 11;
	localparam int CAUSE_LO = 8;
	localparam int CAN_WAKE_BIT = 7;
	localparam int LIN_WAKE_BIT = 6;
	localparam int WAKE_EDGE_BIT = 5;
	localparam int WAKE_LEVEL_BIT = 4;
	localparam int OVERTEMP_BIT = 3;
	localparam int SW_DEV_BIT = 2;
	localparam int ENABLE_BIT = 1;
	localparam int POWERON_BIT = 0;
	localparam int MODE_BITS = 12;
	localparam logic [1:0] STATUS_ADDR = 2'h0;
	localparam logic POWERON_RESET_VAL = 1'h1;
	localparam logic [3:0] TOP_NIBBLE_VAL = 4'h0;

	typedef enum logic [3:0] {
		CAUSE_POR = 4'h0,
		CAUSE_CYCLIC_WAKE = 4'h1,
		CAUSE_MICRO_UV = 4'h2,
		CAUSE_STANDBY_OC = 4'h3,
		CAUSE_AUX_OVERLOAD = 4'h4,
		CAUSE_FLASH_LEFT = 4'h5,
		CAUSE_FLASH_READY = 4'h6,
		CAUSE_CAN_WAKE = 4'h7,
		CAUSE_LIN_WAKE = 4'h8,
		CAUSE_LOCAL_WAKE = 4'h9,
		CAUSE_FAILSAFE_WAKE = 4'hA,
		CAUSE_WDOG_OVERFLOW = 4'hB,
		CAUSE_WDOG_INIT = 4'hC,
		CAUSE_WDOG_EARLY = 4'hD,
		CAUSE_ILLEGAL_SPI = 4'hE,
		CAUSE_IRQ_TIMEOUT = 4'hF
	} cause_t;
	localparam cause_t CAUSE_RESET_VAL = CAUSE_POR;
endpackage
`default_nettype wire

// ---- testbench/spi_host_model.sv ----
// host serial master model that runs frames on the status link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic sck_out,
	output logic cs_n_out,
	output logic sdi_out,
	input wire logic sdo_in
);
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// clock stands still outside frames; odd lead time keeps phase unrelated
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n_out = 1'b0;
		#37;
		for (int i = 15; i >= 0; i--) begin
			sdi_out = tx[i];
			#16;
			rx = {rx[14:0], sdo_in};
			sck_out = 1'b1;
			#16;
			sck_out = 1'b0;
		end
		// data line flips once released so a stale bit never looks valid
		sdi_out = ~tx[0];
		cs_n_out = 1'b1;
		#64;
	endtask
endmodule // spi_host_model
`default_nettype wire

// ---- testbench/test_system_status_readback.sv ----
// self-checking bench for the system status readback block
`timescale 1ns/1ps
`default_nettype none
module test_system_status_readback;
	import status_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic can_w = 1'b0, lin_w = 1'b0, wk = 1'b1, ot = 1'b0;
	logic sd = 1'b0, en = 1'b0, norm = 1'b0, ce = 1'b1;
	logic [15:0] ev = 16'h0000, rx, sword, mdata_prev;
	logic [11:0] mdata, d;
	logic sck, cs_n, sdi, sdo, sdo_oe, mwr;
	int error_cnt = 0, num_checks = 0, cyc = 0, wr_cnt = 0, w0;
	always #4 clk = ~clk;
	system_status_readback i_system_status_readback (.CLK_IN(clk),
		.RESET_N_IN(rst_n), .CE_IN(ce), .SPI_SCK_IN(sck),
		.SPI_CS_N_IN(cs_n), .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo),
		.SPI_SDO_OE_OUT(sdo_oe), .CAN_WAKE_IN(can_w), .LIN_WAKE_IN(lin_w),
		.WAKE_PIN_IN(wk), .OVERTEMP_IN(ot), .SW_DEV_MODE_IN(sd),
		.ENABLE_PIN_STATE_IN(en), .NORMAL_ENTERED_IN(norm),
		.RESET_EVENTS_IN(ev), .MODE_WRITE_OUT(mwr), .MODE_DATA_OUT(mdata),
		.STATUS_WORD_OUT(sword));
	spi_host_model i_spi_host_model (.sck_out(sck), .cs_n_out(cs_n),
		.sdi_out(sdi), .sdo_in(sdo_oe ? sdo : ~sdo));
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ceiling is about fourteen times the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (mwr === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
		end
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	function automatic logic [15:0] exp_word(input logic [3:0] c,
		input logic [2:0] st, input logic pw);
		return {4'h0, c, st, wk, ot, sd, en, pw};
	endfunction
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic [15:0] e, input logic c, input logic l);
		ev = e;
		can_w = c;
		lin_w = l;
		cycles(1);
		ev = 16'h0000;
		can_w = 1'b0;
		lin_w = 1'b0;
		cycles(5);
	endtask
	task automatic rd();
		i_spi_host_model.xfer({STATUS_ADDR, 2'h3, 12'hFFF}, rx);
		cycles(10);
	endtask
	initial begin
		void'($urandom(32'h2E7A));
		cycles(10);
		rst_n = 1'b1;
		cycles(4);
		rd();
		chk("status word", exp_word(4'h0, 3'h0, 1'b1), rx);
		chk("write count", 16'h0, 16'(wr_cnt));
		chk("drive enable", 16'h0, 16'(sdo_oe));
		$display("test read-only after power-on done");
		for (int i = 0; i < 16; i++) begin
			{ot, sd, en} = 3'($urandom);
			pulse(16'h0001 << i, 1'b0, 1'b0);
			chk("cause", exp_word(4'(i), 3'h0, 1'b1), sword);
		end
		pulse(16'h0104, 1'b0, 1'b0);
		rd();
		chk("cause kept", exp_word(4'h8, 3'h0, 1'b1), rx);
		$display("test reset causes done");
		wk = 1'b0;
		pulse(16'h0000, 1'b1, 1'b1);
		rd();
		chk("wake flags", exp_word(4'h8, 3'h7, 1'b1), rx);
		wk = 1'b1;
		cycles(5);
		rd();
		chk("flags cleared", exp_word(4'h8, 3'h0, 1'b1), rx);
		$display("test sticky wake flags done");
		for (int k = 0; k < 9; k++) begin
			{ot, sd, en} = 3'($urandom);
			cycles(3);
			d = 12'($urandom);
			w0 = wr_cnt;
			mdata_prev = 16'(mdata);
			i_spi_host_model.xfer({(k % 3 == 2) ? 2'h1 : STATUS_ADDR,
				(k % 3 != 1), 1'b0, d}, rx);
			cycles(10);
			chk("frame word", exp_word(4'h8, 3'h0, 1'b1), rx);
			chk("write count", 16'(k % 3 == 0), 16'(wr_cnt - w0));
			chk("mode data", (k % 3 == 0) ? 16'(d) : mdata_prev,
				16'(mdata));
		end
		$display("test mode write-through done");
		norm = 1'b1;
		cycles(1);
		norm = 1'b0;
		cycles(5);
		chk("power-on cleared", exp_word(4'h8, 3'h0, 1'b0), sword);
		pulse(16'h0001, 1'b0, 1'b0);
		chk("power-on set", exp_word(4'h0, 3'h0, 1'b1), sword);
		$display("test power-on flag done");
		ce = 1'b0;
		pulse(16'h0800, 1'b1, 1'b0);
		ce = 1'b1;
		cycles(2);
		chk("enable low", exp_word(4'h0, 3'h0, 1'b1), sword);
		$display("test clock enable done");
		pulse(16'h4000, 1'b1, 1'b0);
		chk("before reset", exp_word(4'hE, 3'h4, 1'b1), sword);
		norm = 1'b1;
		cycles(1);
		norm = 1'b0;
		rst_n = 1'b0;
		cycles(2);
		rst_n = 1'b1;
		cycles(4);
		rd();
		chk("after reset", exp_word(4'h0, 3'h0, 1'b1), rx);
		chk("mode after reset", 16'h0, 16'(mdata));
		$display("test mid-run reset done");
		results();
	end
endmodule // test_system_status_readback
`default_nettype wire
